// >>> pmc_pkg.sv
package pmc_pkg;

  // ==========================================================================
  // Register map and field layout
  // ==========================================================================
  localparam logic [15:0] PMC_OFS_ONE      = 16'hfff0;
  localparam logic [15:0] PMC_OFS_TWO      = 16'hfff1;
  localparam logic [7:0]  PMC_RST_ONE      = 8'h07;
  localparam logic [7:0]  PMC_RST_TWO      = 8'he0;
  localparam logic [7:0]  PMC_RSV_ONE      = 8'h04;
  localparam logic [7:0]  PMC_RSV_TWO      = 8'he0;
  localparam int          PMC_STBY_BIT     = 7;
  localparam int          PMC_SETTLE_LO    = 4;
  localparam int          PMC_SUBCLK_BIT   = 3;
  localparam int          PMC_MDIV_LO      = 0;
  localparam int          PMC_NOISE_BIT    = 4;
  localparam int          PMC_DIRECT_BIT   = 3;
  localparam int          PMC_MEDSEL_BIT   = 2;
  localparam int          PMC_SDIV_LO      = 0;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int          PMC_SETTLE_BASE  = 8192;
  localparam int          PMC_SETTLE_W     = 18;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [3:0] {
    pmc_act_hi,
    pmc_act_med,
    pmc_slp_hi,
    pmc_slp_med,
    pmc_standby,
    pmc_watch,
    pmc_subact,
    pmc_subslp,
    pmc_settle
  } pmc_mode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } pmc_bus_req_t;

  typedef struct packed {
    logic        osc_run;
    logic        cpu_run;
    logic        sub_clk;
    logic        settling;
    logic [7:0]  med_div;
    logic [3:0]  sub_div;
    logic [4:0]  noise_div;
  } pmc_clk_ctrl_t;

endpackage : pmc_pkg

// >>> pmc_power_mode_control.sv
// Overview of operation
// - First register resets to 0x07.
// - Standby select clear: SLEEP enters sleep/subsleep.
// - Standby select set: SLEEP enters standby/watch.
// - Settle field picks 8192 to 131072 states.
// - Wake from standby/watch to active waits settle count.
// - Subclock select picks CPU clock after watch.
// - Bit 2 reads one, ignores writes.
// - Medium divider gives /16 to /128.
// - Second register resets to 0xE0.
// - Bits 7..5 read one, ignore writes.
// - Noise select samples at /16 or /4.
// - Direct bit clear: normal low-power entries.
// - Direct from high-speed: medium or subactive.
// - Direct from medium-speed: high or subactive.
// - Direct from subactive: active high/medium.
// - Medium select picks resume and sleep speed.
// - Subactive divider gives /8, /4, /2.
// - Subactive divider writes ignored in subactive.
module pmc_power_mode_control #(
  parameter int SETTLE_BASE = pmc_pkg::PMC_SETTLE_BASE
) (
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  input  wire pmc_pkg::pmc_bus_req_t  bus_req,
  output logic [7:0]                  rdata,
  input  wire logic                   sleep_exec,
  input  wire logic                   wake_irq,
  input  wire logic                   timer_watch_bit,
  output pmc_pkg::pmc_mode_t          mode,
  output pmc_pkg::pmc_clk_ctrl_t      clk_ctrl
);
  import pmc_pkg::*;

  // ==========================================================================
  // Decoding helpers
  // ==========================================================================
  function automatic logic [PMC_SETTLE_W-1:0] settle_cycles(input logic [2:0] fld);
    logic [2:0] sh;
    sh = fld[2] ? 3'h4 : {1'b0, fld[1:0]};
    return PMC_SETTLE_W'(SETTLE_BASE) << sh;
  endfunction : settle_cycles

  function automatic logic [7:0] med_ratio(input logic [1:0] code);
    return 8'h10 << code;
  endfunction : med_ratio

  function automatic logic [3:0] sub_ratio(input logic [1:0] code);
    return code[1] ? 4'h2 : (code[0] ? 4'h4 : 4'h8);
  endfunction : sub_ratio

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [7:0]              one_r;
  logic [7:0]              two_r;
  logic [7:0]              rdata_r;
  pmc_mode_t               state_r;
  pmc_mode_t               target_r;
  logic [PMC_SETTLE_W-1:0] settle_cnt_r;
  pmc_clk_ctrl_t           clk_ctrl_r;

  logic       stby;
  logic       sub_sel;
  logic       direct;
  logic       med_sel;
  logic [2:0] settle_fld;
  logic       wr_one;
  logic       wr_two;
  logic       in_subact;

  assign stby       = one_r[PMC_STBY_BIT];
  assign sub_sel    = one_r[PMC_SUBCLK_BIT];
  assign settle_fld = one_r[PMC_SETTLE_LO +: 3];
  assign direct     = two_r[PMC_DIRECT_BIT];
  assign med_sel    = two_r[PMC_MEDSEL_BIT];
  assign wr_one     = bus_req.wr && (bus_req.addr == PMC_OFS_ONE);
  assign wr_two     = bus_req.wr && (bus_req.addr == PMC_OFS_TWO);
  assign in_subact  = (state_r == pmc_subact);

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      one_r <= PMC_RST_ONE;
    else if (wr_one)
      one_r <= bus_req.wdata | PMC_RSV_ONE;
  end

  // The divider field holds while the CPU runs on the slow clock, so a stray
  // write cannot change the rate under the running code.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      two_r <= PMC_RST_TWO;
    else if (wr_two)
    begin
      two_r <= (bus_req.wdata | PMC_RSV_TWO);
      if (in_subact)
        two_r[PMC_SDIV_LO +: 2] <= two_r[PMC_SDIV_LO +: 2];
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      rdata_r <= 8'h00;
    else if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        PMC_OFS_ONE: rdata_r <= one_r;
        PMC_OFS_TWO: rdata_r <= two_r;
        default:     rdata_r <= 8'h00;
      endcase
    end
    else
      rdata_r <= 8'h00;
  end

  // ==========================================================================
  // Mode sequencer
  // ==========================================================================
  // All decisions read the registers as they stand before any write in the
  // same cycle, which matches the instruction order seen by the CPU.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r      <= pmc_act_hi;
      target_r     <= pmc_act_hi;
      settle_cnt_r <= '0;
    end
    else
    begin
      unique case (state_r)
        pmc_act_hi, pmc_act_med:
          if (sleep_exec)
          begin
            if (!direct)
            begin
              if (!stby)
                state_r <= med_sel ? pmc_slp_med : pmc_slp_hi;
              else
                state_r <= timer_watch_bit ? pmc_watch : pmc_standby;
            end
            else if (stby && timer_watch_bit && sub_sel)
              state_r <= pmc_subact;
            else if (!stby && !sub_sel && state_r == pmc_act_hi && med_sel)
              state_r <= pmc_act_med;
            else if (!stby && !sub_sel && state_r == pmc_act_med && !med_sel)
              state_r <= pmc_act_hi;
          end
        pmc_subact:
          if (sleep_exec)
          begin
            if (!direct)
              state_r <= stby ? pmc_watch : pmc_subslp;
            else if (stby && timer_watch_bit && !sub_sel)
            begin
              state_r      <= pmc_settle;
              target_r     <= med_sel ? pmc_act_med : pmc_act_hi;
              settle_cnt_r <= settle_cycles(settle_fld);
            end
          end
        pmc_slp_hi:
          if (wake_irq)
            state_r <= pmc_act_hi;
        pmc_slp_med:
          if (wake_irq)
            state_r <= pmc_act_med;
        pmc_subslp:
          if (wake_irq)
            state_r <= pmc_subact;
        pmc_standby, pmc_watch:
          if (wake_irq)
          begin
            if (state_r == pmc_watch && sub_sel)
              state_r <= pmc_subact;
            else
            begin
              state_r      <= pmc_settle;
              target_r     <= med_sel ? pmc_act_med : pmc_act_hi;
              settle_cnt_r <= settle_cycles(settle_fld);
            end
          end
        pmc_settle:
          if (settle_cnt_r <= PMC_SETTLE_W'(1))
          begin
            state_r      <= target_r;
            settle_cnt_r <= '0;
          end
          else
            settle_cnt_r <= settle_cnt_r - PMC_SETTLE_W'(1);
        default:
          state_r <= pmc_act_hi;
      endcase
    end
  end

  // ==========================================================================
  // Clock generator controls
  // ==========================================================================
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      clk_ctrl_r <= '{osc_run: 1'b1, cpu_run: 1'b1, sub_clk: 1'b0, settling: 1'b0,
                      med_div: 8'h80, sub_div: 4'h8, noise_div: 5'h10};
    else
    begin
      clk_ctrl_r.osc_run   <= !(state_r inside {pmc_standby, pmc_watch, pmc_subact, pmc_subslp});
      clk_ctrl_r.cpu_run   <= (state_r inside {pmc_act_hi, pmc_act_med, pmc_subact});
      clk_ctrl_r.sub_clk   <= (state_r inside {pmc_subact, pmc_subslp});
      clk_ctrl_r.settling  <= (state_r == pmc_settle);
      clk_ctrl_r.med_div   <= med_ratio(one_r[PMC_MDIV_LO +: 2]);
      clk_ctrl_r.sub_div   <= sub_ratio(two_r[PMC_SDIV_LO +: 2]);
      clk_ctrl_r.noise_div <= two_r[PMC_NOISE_BIT] ? 5'h04 : 5'h10;
    end
  end

  assign rdata    = rdata_r;
  assign mode     = state_r;
  assign clk_ctrl = clk_ctrl_r;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  AST_RST_VALUES: assert property ($rose(nrst) |-> one_r == 8'h07 && two_r == 8'he0)
    else $error("Control registers not at reset values.");
  AST_RSV_ONE: assert property (one_r[2] == 1'b1)
    else $error("Reserved bit 2 of first register is not one.");
  AST_RSV_TWO: assert property (two_r[7:5] == 3'b111)
    else $error("Reserved bits of second register are not one.");
  AST_SLEEP_ENTRY: assert property ((state_r == pmc_act_hi) && sleep_exec && !stby && !direct
                                    |=> state_r == ($past(med_sel) ? pmc_slp_med : pmc_slp_hi))
    else $error("SLEEP with standby clear did not enter sleep.");
  AST_WATCH_ENTRY: assert property (in_subact && sleep_exec && stby && !direct |=> state_r == pmc_watch)
    else $error("SLEEP in subactive with standby set did not enter watch.");
  AST_SETTLE_LOAD: assert property ((state_r == pmc_standby) && wake_irq
                                    |=> settle_cnt_r == settle_cycles($past(settle_fld)) && state_r == pmc_settle)
    else $error("Settle count not loaded from field.");
  AST_SETTLE_HOLD: assert property ((state_r == pmc_settle) && settle_cnt_r > 18'h1
                                    |=> state_r == pmc_settle ##1 clk_ctrl_r.cpu_run == 1'b0)
    else $error("CPU released before settle count expired.");
  AST_MED_DIV: assert property (##1 clk_ctrl_r.med_div == (8'h10 << $past(one_r[1:0])))
    else $error("Medium-speed divider output wrong.");
  AST_NOISE: assert property (two_r[4] |=> clk_ctrl_r.noise_div == 5'h04)
    else $error("Noise sampling rate wrong.");
  AST_DIRECT_SUB: assert property ((state_r == pmc_act_hi) && sleep_exec && direct && stby && timer_watch_bit && sub_sel
                                   |=> state_r == pmc_subact ##2 clk_ctrl_r.sub_clk)
    else $error("Direct transfer to subactive failed.");
  AST_DIRECT_ACT: assert property (in_subact && sleep_exec && direct && stby && timer_watch_bit && !sub_sel
                                   |=> state_r == pmc_settle && target_r == ($past(med_sel) ? pmc_act_med : pmc_act_hi))
    else $error("Direct transfer from subactive failed.");
  AST_SDIV_LOCK: assert property (in_subact && wr_two |=> two_r[1:0] == $past(two_r[1:0]))
    else $error("Subactive divider changed in subactive mode.");
  AST_SUB_DIV: assert property (two_r[1] |=> clk_ctrl_r.sub_div == 4'h2)
    else $error("Subactive divider output wrong.");

  // ==========================================================================
  // Register write and read checks
  // ==========================================================================
  // Expected values are built from the written data and the fixed reserved
  // masks, so a broken merge of the reserved bits shows up here.
  AST_WR_ONE: assert property (wr_one
    |=> one_r == ($past(bus_req.wdata) | 8'h04))
    else $error("First register write did not land.");

  AST_WR_TWO_ACT: assert property (wr_two && !in_subact
    |=> two_r == ($past(bus_req.wdata) | 8'he0))
    else $error("Second register write did not land.");

  AST_WR_TWO_SUB: assert property (wr_two && in_subact
    |=> two_r[7:2] == ($past(bus_req.wdata[7:2]) | 6'h38))
    else $error("Second register upper fields not written in subactive.");

  AST_RD_ONE: assert property (bus_req.rd && bus_req.addr == PMC_OFS_ONE
    |=> rdata_r == $past(one_r))
    else $error("First register read data wrong.");

  AST_RD_TWO: assert property (bus_req.rd && bus_req.addr == PMC_OFS_TWO
    |=> rdata_r == $past(two_r))
    else $error("Second register read data wrong.");

  // ==========================================================================
  // Mode entry checks
  // ==========================================================================
  AST_SLEEP_MED: assert property (state_r == pmc_act_med && sleep_exec && !stby && !direct
    |=> state_r == ($past(med_sel) ? pmc_slp_med : pmc_slp_hi))
    else $error("SLEEP from medium speed did not enter sleep.");

  AST_SUBSLEEP: assert property (in_subact && sleep_exec && !stby && !direct
    |=> state_r == pmc_subslp)
    else $error("SLEEP in subactive did not enter subsleep.");

  AST_STBY_ENTRY: assert property (state_r inside {pmc_act_hi, pmc_act_med} && sleep_exec && stby && !direct
    |=> state_r == ($past(timer_watch_bit) ? pmc_watch : pmc_standby))
    else $error("SLEEP with standby set did not enter standby or watch.");

  AST_DIRECT_MED: assert property (state_r == pmc_act_hi && sleep_exec && direct && !stby && med_sel && !sub_sel
    |=> state_r == pmc_act_med)
    else $error("Direct transfer to medium speed failed.");

  AST_DIRECT_HI: assert property (state_r == pmc_act_med && sleep_exec && direct && !stby && !med_sel && !sub_sel
    |=> state_r == pmc_act_hi)
    else $error("Direct transfer to high speed failed.");

  AST_DIRECT_MSUB: assert property (state_r == pmc_act_med && sleep_exec && direct && stby && timer_watch_bit && sub_sel
    |=> state_r == pmc_subact)
    else $error("Direct transfer from medium speed to subactive failed.");

  AST_DIRECT_STAY: assert property (in_subact && sleep_exec && direct && !(stby && timer_watch_bit)
    |=> state_r == pmc_subact)
    else $error("Unmatched direct transfer left subactive.");

  // ==========================================================================
  // Wake-up checks
  // ==========================================================================
  AST_WATCH_SUB: assert property (state_r == pmc_watch && wake_irq && sub_sel
    |=> state_r == pmc_subact)
    else $error("Watch exit with subclock select did not reach subactive.");

  AST_WATCH_SETTLE: assert property (state_r == pmc_watch && wake_irq && !sub_sel
    |=> state_r == pmc_settle && target_r == ($past(med_sel) ? pmc_act_med : pmc_act_hi))
    else $error("Watch exit to active did not start the settle wait.");

  AST_STBY_TARGET: assert property (state_r == pmc_standby && wake_irq
    |=> target_r == ($past(med_sel) ? pmc_act_med : pmc_act_hi))
    else $error("Standby exit resume speed wrong.");

  AST_SLEEP_WAKE: assert property (state_r == pmc_slp_hi && wake_irq
    |=> state_r == pmc_act_hi)
    else $error("Sleep high-speed exit wrong.");

  AST_SLEEP_MED_WAKE: assert property (state_r == pmc_slp_med && wake_irq
    |=> state_r == pmc_act_med)
    else $error("Sleep medium-speed exit wrong.");

  AST_LOW_HOLD: assert property (state_r inside {pmc_slp_hi, pmc_slp_med, pmc_subslp, pmc_standby, pmc_watch}
    && !wake_irq |=> state_r == $past(state_r))
    else $error("Low-power mode left without a wake event.");

  AST_SETTLE_MAX: assert property (state_r == pmc_standby && wake_irq && settle_fld[2]
    |=> settle_cnt_r == PMC_SETTLE_W'(SETTLE_BASE << 4))
    else $error("Longest settle count not loaded.");

  // ==========================================================================
  // Settle wait checks
  // ==========================================================================
  AST_SETTLE_DOWN: assert property (state_r == pmc_settle && settle_cnt_r > 18'h1
    |=> settle_cnt_r == $past(settle_cnt_r) - 18'h1)
    else $error("Settle count did not step down.");

  AST_SETTLE_END: assert property (state_r == pmc_settle && settle_cnt_r == 18'h1
    |=> state_r == $past(target_r))
    else $error("Settle wait did not end in the target mode.");

  AST_SETTLE_FLAG: assert property (state_r == pmc_settle
    |=> clk_ctrl_r.settling && !clk_ctrl_r.cpu_run)
    else $error("Settle wait not shown to the clock generator.");

  // ==========================================================================
  // Clock generator output checks
  // ==========================================================================
  AST_OSC_STOP: assert property (state_r inside {pmc_standby, pmc_watch}
    |=> !clk_ctrl_r.osc_run && !clk_ctrl_r.cpu_run)
    else $error("Clocks still running in standby or watch.");

  AST_SUB_CLK: assert property (in_subact
    |=> clk_ctrl_r.sub_clk && clk_ctrl_r.cpu_run)
    else $error("Subactive mode not on the subclock.");

  AST_SUB_DIV_FOUR: assert property (two_r[1:0] == 2'b01
    |=> clk_ctrl_r.sub_div == 4'h4)
    else $error("Subactive divider by four wrong.");

  AST_SUB_DIV_EIGHT: assert property (two_r[1:0] == 2'b00
    |=> clk_ctrl_r.sub_div == 4'h8)
    else $error("Subactive divider by eight wrong.");

  AST_NOISE_SLOW: assert property (!two_r[4]
    |=> clk_ctrl_r.noise_div == 5'h10)
    else $error("Slow noise sampling rate wrong.");

endmodule : pmc_power_mode_control

// >>> pmc_cpu_model.sv
module pmc_cpu_model (
  input  wire logic             mclk,
  output pmc_pkg::pmc_bus_req_t bus_req,
  input  wire logic [7:0]       rdata,
  output logic                  sleep_exec,
  output logic                  wake_irq,
  output logic                  timer_watch_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  import pmc_pkg::*;

  // ==========================================================================
  // Idle levels
  // ==========================================================================
  initial
  begin
    bus_req         = '0;
    sleep_exec      = 1'b0;
    wake_irq        = 1'b0;
    timer_watch_bit = 1'b0;
  end

  // ==========================================================================
  // Register access and instruction events
  // ==========================================================================
  // Callers write only sane settings: a long enough settle field, divider changes
  // from high-speed or subactive mode, noise select clear at mid rates.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic pulse(input bit is_wake);
    @(posedge mclk);
    if (is_wake)
      wake_irq <= 1'b1;
    else
      sleep_exec <= 1'b1;
    @(posedge mclk);
    wake_irq   <= 1'b0;
    sleep_exec <= 1'b0;
  endtask : pulse

  task automatic tw(input logic v);
    @(posedge mclk);
    timer_watch_bit <= v;
  endtask : tw
endmodule : pmc_cpu_model

// >>> tb_power_mode_control.sv
module tb_power_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  import pmc_pkg::*;

  // A short settle base keeps the longest wait at 64 cycles.
  localparam int BASE = 4;

  logic          mclk = 1'b0;
  logic          nrst = 1'b0;
  pmc_bus_req_t  bus_req;
  logic [7:0]    rdata;
  logic          sleep_exec;
  logic          wake_irq;
  logic          timer_watch_bit;
  pmc_mode_t     mode;
  pmc_clk_ctrl_t clk_ctrl;
  int            failures = 0;
  int            tests_run = 0;
  int            n;

  always #2 mclk = ~mclk;

  pmc_power_mode_control #(.SETTLE_BASE(BASE)) dut (
    .mclk(mclk), .nrst(nrst), .bus_req(bus_req), .rdata(rdata), .sleep_exec(sleep_exec),
    .wake_irq(wake_irq), .timer_watch_bit(timer_watch_bit), .mode(mode), .clk_ctrl(clk_ctrl));

  pmc_cpu_model cpu (
    .mclk(mclk), .bus_req(bus_req), .rdata(rdata), .sleep_exec(sleep_exec),
    .wake_irq(wake_irq), .timer_watch_bit(timer_watch_bit));

  // ==========================================================================
  // Checking helpers
  // ==========================================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] v;
    cpu.rd(a, v);
    chk(v, exp);
  endtask : rchk

  // Mode is registered, so it is looked at just after the edge that took the pulse.
  task automatic mchk(input bit w, input pmc_mode_t exp);
    cpu.pulse(w);
    #1;
    chk(mode, exp);
  endtask : mchk

  task automatic settle_cnt(output int c);
    c = 0;
    while (mode === pmc_settle && c < 300)
    begin
      @(posedge mclk);
      #1;
      c++;
    end
  endtask : settle_cnt

  task automatic wclk(input logic [15:0] a, input logic [7:0] d);
    cpu.wr(a, d);
    @(posedge mclk);
    #1;
  endtask : wclk

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask : end_test

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial
  begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    #1;
    chk(mode, pmc_act_hi);
    chk(clk_ctrl.med_div, 8'd128);
    chk({clk_ctrl.sub_div, clk_ctrl.noise_div}, {4'd8, 5'd16});
    rchk(16'hfff0, 8'h07);
    rchk(16'hfff1, 8'he0);
    cpu.wr(16'hfff0, 8'h00);
    rchk(16'hfff0, 8'h04);
    cpu.wr(16'hfff1, 8'h00);
    rchk(16'hfff1, 8'he0);
    rchk(16'hfff2, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wclk(16'hfff0, 8'(i));
      chk(clk_ctrl.med_div, 8'd16 << i);
      wclk(16'hfff1, 8'(i));
      chk(clk_ctrl.sub_div, (i > 1) ? 4'd2 : (4'd8 >> i));
    end
    wclk(16'hfff1, 8'h10);
    chk(clk_ctrl.noise_div, 5'd4);
    end_test("registers");
    cpu.wr(16'hfff0, 8'h00);
    for (int ms = 0; ms < 2; ms++)
    begin
      cpu.wr(16'hfff1, 8'(ms << 2));
      mchk(0, ms ? pmc_slp_med : pmc_slp_hi);
      mchk(1, ms ? pmc_act_med : pmc_act_hi);
    end
    cpu.wr(16'hfff1, 8'h00);
    cpu.tw(1'b0);
    for (int f = 0; f < 8; f++)
    begin
      cpu.wr(16'hfff0, {1'b1, 3'(f), 4'h0});
      mchk(0, pmc_standby);
      @(posedge mclk);
      #1;
      chk({clk_ctrl.osc_run, clk_ctrl.cpu_run}, 2'b00);
      cpu.pulse(1);
      #1;
      @(posedge mclk);
      #1;
      chk(clk_ctrl.settling, 1'b1);
      settle_cnt(n);
      chk(n + 1, BASE << ((f > 3) ? 4 : f));
      chk(mode, pmc_act_hi);
    end
    end_test("sleep and standby");
    cpu.wr(16'hfff0, 8'h88);
    cpu.tw(1'b1);
    mchk(0, pmc_watch);
    mchk(1, pmc_subact);
    @(posedge mclk);
    #1;
    chk({clk_ctrl.sub_clk, clk_ctrl.osc_run, clk_ctrl.cpu_run}, 3'b101);
    cpu.wr(16'hfff1, 8'h01);
    rchk(16'hfff1, 8'he0);
    cpu.wr(16'hfff0, 8'h08);
    mchk(0, pmc_subslp);
    mchk(1, pmc_subact);
    cpu.wr(16'hfff0, 8'h88);
    mchk(0, pmc_watch);
    mchk(1, pmc_subact);
    end_test("watch and subactive");
    cpu.wr(16'hfff1, 8'h0c);
    mchk(0, pmc_subact);
    cpu.wr(16'hfff0, 8'h80);
    cpu.pulse(0);
    #1;
    settle_cnt(n);
    chk(n, BASE);
    chk(mode, pmc_act_med);
    cpu.wr(16'hfff1, 8'h08);
    cpu.wr(16'hfff0, 8'h00);
    mchk(0, pmc_act_hi);
    cpu.wr(16'hfff1, 8'h0c);
    mchk(0, pmc_act_med);
    cpu.wr(16'hfff0, 8'h88);
    mchk(0, pmc_subact);
    cpu.wr(16'hfff0, 8'h80);
    cpu.wr(16'hfff1, 8'h08);
    cpu.pulse(0);
    #1;
    settle_cnt(n);
    chk(mode, pmc_act_hi);
    cpu.wr(16'hfff0, 8'h88);
    mchk(0, pmc_subact);
    end_test("direct transfer");
    give_verdict();
  end

  // ==========================================================================
  // Watchdog
  // ==========================================================================
  initial
  begin
    #100000;
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule : tb_power_mode_control
